// ==== rsmc_strap_capture.sv ====
// Reset strap capture with flag pins, interrupt inputs and timer output
`timescale 1ns/1ps
`include "rsmc_map.svh"

// Summary of operation
// [R1] While reset is held the strap pins are sampled to pick operating modes.
// [R2] Strap pins act as straps only in reset and as ordinary pins otherwise.
// [R3] An undriven strap pin yields its built-in default level.
// [R4] Boot strap 0 boots from boot memory at once; 1 idles awaiting a load.
// [R5] Interrupt strap 0 leaves requests disabled and edge; 1 enables level.
// [R6] Link width strap 0 selects 1-bit receive, 1 selects 4-bit receive.
// [R7] Config write strap 0 allows one write to each config reg, 1 allows all.
// [R8] The board leaves the three test-mode straps at their defaults.
// [R9] Each flag pin is separately input or output and readable as a condition.
// [R10] All flag pins come up as inputs after every reset.
// [R11] An asserted request raises an interrupt, edge or level per input.
// [R12] Requests stay disabled after reset unless the strap and vectors allow.
// [R13] The timer pin pulses on timer expiry outside reset, a strap in reset.
// [R14] Straps latch on the rising edge of the reset input.
// [R15] Shortly after reset release strap pins return to normal outputs.
// [R16] Captured straps hold against later pin activity until the next reset.
// [R17] In one-write mode a first accepted write clears a per-register permit.
module rsmc_strap_capture #(
    parameter int FLAGS = 4,
    parameter int IRQS = 4,
    parameter logic [6:0] STRAP_DEFAULT = `RSMC_STRAP_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Strap pins: input, output, enable
    input wire logic [6:0] strapPinIn,
    output logic [6:0] strapPinOut,
    output logic [6:0] strapPinOe,
    output logic [6:0] strapPullUp,
    // Run-time sources for the shared pins
    input wire logic bootMemorySelect,
    input wire logic busMasterIndicator,
    input wire logic [2:0] linkCompareOut,
    input wire logic lockedTransferPin,
    // General flag pins
    input wire logic [FLAGS-1:0] flagIn,
    output logic [FLAGS-1:0] flagOut,
    output logic [FLAGS-1:0] flagOe,
    // Interrupt request pins
    input wire logic [IRQS-1:0] irqIn,
    input wire logic vectorsReady,
    // Decoded modes and interrupt outputs
    output logic bootFromMemory,
    output logic waitForLoad,
    output logic linkWide,
    output logic [IRQS-1:0] irqEvent,
    output logic irq,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    rsmc_pkg::rsmc_phase_t phase_r;
    logic [6:0] strap_r;
    logic [6:0] sample_r;
    logic [1:0] relCnt_r;
    logic [FLAGS-1:0] flagDir_r;
    logic [FLAGS-1:0] flagOut_r;
    logic [FLAGS-1:0] flagIn_r;
    logic [IRQS-1:0] interrupt_enable_strap_r;
    logic [IRQS-1:0] irqLevel_r;
    logic [31:0] sysCfg_r;
    logic [31:0] sdrCfg_r;
    logic sysPermit_r;
    logic sdrPermit_r;
    logic [4:0] status_r;
    logic [4:0] mask_r;
    logic [15:0] timerLoad_r;
    logic [15:0] timerCnt_r;
    logic timerRun_r;
    logic [2:0] expireCnt_r;
    logic expire;
    logic ack_r;
    logic [31:0] rdat_r;
    logic wbReq;
    logic wbWr;
    logic inRun;
    logic [4:0] irqEvt5;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign wbReq = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wbWr = wbReq & wb_we_i;
    assign inRun = (phase_r == rsmc_pkg::PH_RUN);

    // Sample straps every cycle in reset; the sampler itself is reset-free
    // so the last value before the rising edge survives into the release.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sample_r <= strapPinIn; // [R1] [R3]
        end
    end

    // Phase: reset, a short release window, then normal pin functions
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= rsmc_pkg::PH_RESET;
            relCnt_r <= 2'h0;
        end else begin
            case (phase_r)
                rsmc_pkg::PH_RESET: begin
                    phase_r <= rsmc_pkg::PH_RELEASE;
                    relCnt_r <= 2'h0;
                end
                rsmc_pkg::PH_RELEASE: begin
                    relCnt_r <= relCnt_r + 2'h1;
                    if (relCnt_r == 2'(`RSMC_RELEASE_CYC - 1)) begin
                        phase_r <= rsmc_pkg::PH_RUN; // [R15]
                    end
                end
                rsmc_pkg::PH_RUN: phase_r <= rsmc_pkg::PH_RUN;
                default: phase_r <= rsmc_pkg::PH_RESET;
            endcase
        end
    end

    // Capture once, at the first edge after release, then hold
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strap_r <= `RSMC_STRAP_DEFAULT;
        end else if (phase_r == rsmc_pkg::PH_RESET) begin
            strap_r <= sample_r; // [R14] [R16]
        end
    end

    assign bootFromMemory = ~strap_r[`RSMC_STRAP_BOOT] & inRun; // [R4]
    assign waitForLoad = strap_r[`RSMC_STRAP_BOOT] & inRun; // [R4]
    assign linkWide = strap_r[`RSMC_STRAP_LINKW]; // [R6]

    // Pins drive only in normal operation; in reset the pulls show defaults
    always_comb begin
        strapPinOut = {linkCompareOut, lockedTransferPin, expire,
                       busMasterIndicator, bootMemorySelect};
        strapPinOe = inRun ? 7'h7f : 7'h00; // [R2] [R13]
        strapPullUp = inRun ? 7'h09 : STRAP_DEFAULT; // [R3]
    end

    // Flags: inputs after reset, direction per pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flagDir_r <= '0; // [R10]
            flagOut_r <= '0;
            flagIn_r <= '0;
        end else begin
            flagIn_r <= flagIn; // [R9]
            if (wbWr && wb_adr_i == `RSMC_OFF_FLAGDIR && wb_sel_i[0]) begin
                flagDir_r <= wb_dat_i[FLAGS-1:0]; // [R9]
            end
            if (wbWr && wb_adr_i == `RSMC_OFF_FLAGOUT && wb_sel_i[0]) begin
                flagOut_r <= wb_dat_i[FLAGS-1:0];
            end
        end
    end
    assign flagOut = flagOut_r;
    assign flagOe = flagDir_r; // [R9]

    // Interrupt control: defaults come from the strap at release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_enable_strap_r <= '0;
            irqLevel_r <= '0;
        end else if (phase_r == rsmc_pkg::PH_RESET) begin
            interrupt_enable_strap_r <= '0; // [R12]
            irqLevel_r <= {IRQS{sample_r[`RSMC_STRAP_INTERRUPT_ENABLE_STRAP]}}; // [R5]
        end else if (wbWr && wb_adr_i == `RSMC_OFF_IRQCTL && wb_sel_i[0]) begin
            interrupt_enable_strap_r <= wb_dat_i[IRQS-1:0];
            irqLevel_r <= wb_dat_i[IRQS+3:4];
        end else if (strap_r[`RSMC_STRAP_INTERRUPT_ENABLE_STRAP] && vectorsReady &&
                     phase_r == rsmc_pkg::PH_RELEASE) begin
            interrupt_enable_strap_r <= '1; // [R5] [R12]
        end
    end

    rsmc_irq_detect #(.N(IRQS)) u_irq (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .enable(interrupt_enable_strap_r),
        .levelMode(irqLevel_r),
        .reqIn(irqIn),
        .reqEvent(irqEvent)
    );

    // Config registers guarded by the write policy strap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sysCfg_r <= 32'h0;
            sdrCfg_r <= 32'h0;
            sysPermit_r <= 1'b1;
            sdrPermit_r <= 1'b1;
        end else begin
            if (wbWr && wb_adr_i == `RSMC_OFF_SYSCFG && sysPermit_r) begin
                sysCfg_r <= merge(sysCfg_r, wb_dat_i, wb_sel_i); // [R7]
                sysPermit_r <= strap_r[`RSMC_STRAP_CFGWR]; // [R17]
            end
            if (wbWr && wb_adr_i == `RSMC_OFF_SDRCFG && sdrPermit_r) begin
                sdrCfg_r <= merge(sdrCfg_r, wb_dat_i, wb_sel_i); // [R7]
                sdrPermit_r <= strap_r[`RSMC_STRAP_CFGWR]; // [R17]
            end
        end
    end

    // Timer 0: reload count; expiry pulse held long enough for the pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timerLoad_r <= 16'h0;
            timerCnt_r <= 16'h0;
            timerRun_r <= 1'b0;
            expireCnt_r <= 3'h0;
        end else begin
            if (wbWr && wb_adr_i == `RSMC_OFF_TIMER) begin
                timerLoad_r <= wb_dat_i[15:0];
                timerCnt_r <= wb_dat_i[15:0];
                timerRun_r <= wb_dat_i[31];
            end else if (timerRun_r && inRun) begin
                timerCnt_r <= (timerCnt_r == 16'h0) ? timerLoad_r
                              : timerCnt_r - 16'h1;
            end
            if (timerRun_r && inRun && timerCnt_r == 16'h0) begin
                expireCnt_r <= 3'(`RSMC_EXPIRE_PULSE_CYC); // [R13]
            end else if (expireCnt_r != 3'h0) begin
                expireCnt_r <= expireCnt_r - 3'h1;
            end
        end
    end
    assign expire = (expireCnt_r != 3'h0) & inRun; // [R13]

    // Sticky status, set wins over write-one-to-clear
    assign irqEvt5 = {timerRun_r && inRun && timerCnt_r == 16'h0, irqEvent};
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status_r <= 5'h0;
            mask_r <= 5'h0;
        end else begin
            if (wbWr && wb_adr_i == `RSMC_OFF_STATUS && wb_sel_i[0]) begin
                status_r <= (status_r & ~wb_dat_i[4:0]) | irqEvt5; // [R11]
            end else begin
                status_r <= status_r | irqEvt5; // [R11]
            end
            if (wbWr && wb_adr_i == `RSMC_OFF_MASK && wb_sel_i[0]) begin
                mask_r <= wb_dat_i[4:0];
            end
        end
    end
    assign irq = |(status_r & mask_r);

    // Wishbone: one wait state, ack for one cycle, unmapped reads zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= wbReq;
            case (wb_adr_i)
                `RSMC_OFF_STRAP: rdat_r <= {25'h0, strap_r};
                `RSMC_OFF_FLAGDIR: rdat_r <= 32'(flagDir_r);
                `RSMC_OFF_FLAGOUT: rdat_r <= 32'(flagOut_r);
                `RSMC_OFF_FLAGIN: rdat_r <= 32'(flagIn_r);
                `RSMC_OFF_IRQCTL: rdat_r <= {24'h0, 4'(irqLevel_r),
                                             4'(interrupt_enable_strap_r)};
                `RSMC_OFF_SYSCFG: rdat_r <= sysCfg_r;
                `RSMC_OFF_SDRCFG: rdat_r <= sdrCfg_r;
                `RSMC_OFF_STATUS: rdat_r <= {27'h0, status_r};
                `RSMC_OFF_MASK: rdat_r <= {27'h0, mask_r};
                `RSMC_OFF_TIMER: rdat_r <= {timerRun_r, 15'h0, timerCnt_r};
                default: rdat_r <= 32'h0;
            endcase
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    a_strap_hold: assert property ( // [R16]
        (phase_r != rsmc_pkg::PH_RESET) |=> $stable(strap_r))
        else $error("strap changed after capture");
    a_pins_quiet_reset: assert property ( // [R2]
        (phase_r != rsmc_pkg::PH_RUN) |-> (strapPinOe == 7'h00))
        else $error("strap pin driven before release");
    a_release_time: assert property ( // [R15]
        (phase_r == rsmc_pkg::PH_RESET) |-> ##3 inRun)
        else $error("pins not returned to normal in time");
    a_flag_inputs: assert property ( // [R10]
        $rose(resetn) |-> (flagOe == '0))
        else $error("flag driven after reset");
    a_one_write: assert property ( // [R17]
        (!strap_r[`RSMC_STRAP_CFGWR] && !sysPermit_r) |=> $stable(sysCfg_r))
        else $error("config written twice");
    a_boot_select: assert property ( // [R4]
        inRun |-> (bootFromMemory != waitForLoad))
        else $error("boot mode not exclusive");
    a_irq_level_mode: assert property ( // [R5]
        (phase_r == rsmc_pkg::PH_RELEASE) |->
        (irqLevel_r == {IRQS{strap_r[`RSMC_STRAP_INTERRUPT_ENABLE_STRAP]}}))
        else $error("irq sensitivity not from strap");
    a_expire_pulse: assert property ( // [R13]
        $rose(expire) |-> expire[*4])
        else $error("expiry pulse too short");
    a_link_width: assert property ( // [R6]
        (phase_r == rsmc_pkg::PH_RESET) |=>
        (linkWide == $past(strapPinIn[`RSMC_STRAP_LINKW], 2)))
        else $error("link width not taken from the pin");
    a_strap_capture: assert property ( // [R14]
        (phase_r == rsmc_pkg::PH_RESET) |=> (strap_r == $past(sample_r)))
        else $error("strap not captured");

    c_wait_boot: cover property (@(posedge sys_clk) inRun && waitForLoad);
    c_cfg_locked: cover property (@(posedge sys_clk) !sysPermit_r);
    c_irq_fire: cover property (@(posedge sys_clk) irq);
    c_timer_pin: cover property (@(posedge sys_clk) expire);
endmodule : rsmc_strap_capture

// ==== rsmc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef RSMC_MAP_SVH
`define RSMC_MAP_SVH

`define RSMC_OFF_STRAP 8'h00
`define RSMC_OFF_FLAGDIR 8'h04
`define RSMC_OFF_FLAGOUT 8'h08
`define RSMC_OFF_FLAGIN 8'h0c
`define RSMC_OFF_IRQCTL 8'h10
`define RSMC_OFF_SYSCFG 8'h14
`define RSMC_OFF_SDRCFG 8'h18
`define RSMC_OFF_STATUS 8'h1c
`define RSMC_OFF_MASK 8'h20
`define RSMC_OFF_TIMER 8'h24

`define RSMC_STRAP_BOOT 0
`define RSMC_STRAP_INTERRUPT_ENABLE_STRAP 1
`define RSMC_STRAP_LINKW 2
`define RSMC_STRAP_CFGWR 3
`define RSMC_STRAP_TMA 4
`define RSMC_STRAP_TMB 5
`define RSMC_STRAP_TMC 6

`define RSMC_STRAP_DEFAULT 7'h70
`define RSMC_IRQCTL_RESET 8'h00
`define RSMC_STAT_TIMER 4

`define RSMC_EXPIRE_PULSE_NS 100
`define RSMC_CLK_PERIOD_NS 25
`define RSMC_EXPIRE_PULSE_CYC \
    ((`RSMC_EXPIRE_PULSE_NS + `RSMC_CLK_PERIOD_NS - 1) / `RSMC_CLK_PERIOD_NS)
`define RSMC_RELEASE_CYC 2

`endif

// ==== rsmc_pkg.sv ====
// Types shared by the strap capture block
package rsmc_pkg;
    typedef enum logic [1:0] {
        PH_RESET,
        PH_RELEASE,
        PH_RUN
    } rsmc_phase_t;
endpackage : rsmc_pkg

// ==== rsmc_irq_detect.sv ====
// Interrupt request input: edge or level detection per pin
`timescale 1ns/1ps
`include "rsmc_map.svh"
module rsmc_irq_detect #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic [N-1:0] enable,
    input wire logic [N-1:0] levelMode,
    // Pins and events
    input wire logic [N-1:0] reqIn,
    output logic [N-1:0] reqEvent
);
    logic [N-1:0] reqPrev_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reqPrev_r <= '0;
        end else begin
            reqPrev_r <= reqIn;
        end
    end

    // Active-high request; level follows pin, edge fires on rise only
    always_comb begin
        for (int i = 0; i < N; i++) begin
            reqEvent[i] = enable[i] & (levelMode[i] ? reqIn[i]
                          : (reqIn[i] & ~reqPrev_r[i])); // [R11]
        end
    end

    a_disabled_quiet: assert property (@(posedge sys_clk) // [R12]
        disable iff (!resetn) (enable == '0) |-> (reqEvent == '0))
        else $error("irq event while disabled");
endmodule : rsmc_irq_detect

// ==== rsmc_board_model.sv ====
// Board model: strap resistors, external strap logic and flag drivers
`timescale 1ns/1ps
module rsmc_board_model (
    // Device side of the strap pins
    input wire logic [6:0] strapPinOut,
    input wire logic [6:0] strapPinOe,
    input wire logic [6:0] strapPullUp,
    // Device side of the flag pins
    input wire logic [3:0] flagOut,
    input wire logic [3:0] flagOe,
    // Board stimulus
    input wire logic [3:0] strapForce,
    input wire logic [3:0] strapForceEn,
    input wire logic [3:0] flagDrive,
    input wire logic [3:0] flagDriveEn,
    // Resolved pin levels
    output logic [6:0] strapPinIn,
    output logic [3:0] flagIn
);
    logic [6:0] forceEn;
    logic [6:0] forceVal;

    // Test-mode straps never get a resistor, they keep their default
    assign forceEn = {3'b000, strapForceEn};
    assign forceVal = {3'b000, strapForce};

    // Device driver beats the strap resistor, which beats the internal pull
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (strapPinOe[i])
                strapPinIn[i] = strapPinOut[i];
            else if (forceEn[i])
                strapPinIn[i] = forceVal[i];
            else
                strapPinIn[i] = strapPullUp[i];
        end
    end

    // Undriven flag pins float high on their pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (flagOe[i])
                flagIn[i] = flagOut[i];
            else if (flagDriveEn[i])
                flagIn[i] = flagDrive[i];
            else
                flagIn[i] = 1'b1;
        end
    end
endmodule : rsmc_board_model

// ==== reset_strap_mode_capture_test.sv ====
// Self-checking bench for the reset strap capture block
`timescale 1ns/1ps
`include "rsmc_map.svh"
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module reset_strap_mode_capture_test;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] strapPinIn, strapPinOut, strapPinOe, strapPullUp;
    logic bootMemorySelect = 1'b0;
    logic busMasterIndicator = 1'b0;
    logic lockedTransferPin = 1'b0;
    logic [2:0] linkCompareOut = 3'h0;
    logic [3:0] flagIn, flagOut, flagOe, irqEvent;
    logic [3:0] irqIn = 4'h0;
    logic vectorsReady = 1'b0;
    logic bootFromMemory, waitForLoad, linkWide, irq, wb_ack_o;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q, r;
    logic [3:0] strapForce = 4'h0;
    logic [3:0] strapForceEn = 4'h0;
    logic [3:0] flagDrive = 4'h0;
    logic [3:0] flagDriveEn = 4'h0;
    logic [3:0] v;
    logic vr;
    int seed = 32'hefd87c3c;
    int n_fail = 0;
    int tests_run = 0;
    int n;

    always #12.5 sys_clk = ~sys_clk;

    rsmc_strap_capture u_dut (
        .sys_clk, .resetn, .strapPinIn, .strapPinOut, .strapPinOe,
        .strapPullUp, .bootMemorySelect, .busMasterIndicator,
        .linkCompareOut, .lockedTransferPin, .flagIn, .flagOut, .flagOe,
        .irqIn, .vectorsReady, .bootFromMemory, .waitForLoad, .linkWide,
        .irqEvent, .irq, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
    );

    rsmc_board_model u_board (
        .strapPinOut, .strapPinOe, .strapPullUp, .flagOut, .flagOe,
        .strapForce, .strapForceEn, .flagDrive, .flagDriveEn,
        .strapPinIn, .flagIn
    );

    function automatic logic [3:0] flag_level(input logic [3:0] dir,
            input logic [3:0] outv, input logic [3:0] ext);
        return (dir & outv) | (~dir & ext);
    endfunction : flag_level

    task automatic wb(input logic we, input logic [7:0] adr,
            input logic [31:0] dat, output logic [31:0] rq);
        int k;
        k = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1);
        rq = wb_dat_o;
        `CHK(k, 2)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] dq;
        wb(1'b1, adr, dat, dq);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [31:0] rq);
        wb(1'b0, adr, 32'h0, rq);
    endtask : rd

    task automatic do_reset(input logic [3:0] val);
        @(posedge sys_clk);
        resetn <= 1'b0;
        strapForce <= val;
        strapForceEn <= 4'hf;
        repeat (3) @(posedge sys_clk);
        `CHK(strapPinOe, 7'h00)
        `CHK(strapPullUp, `RSMC_STRAP_DEFAULT)
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        strapForceEn <= 4'h0;
        `CHK(strapPinOe, 7'h7f)
        `CHK(strapPullUp, 7'h09)
    endtask : do_reset

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // The sequence needs a few hundred cycles; this is a wide margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(`RSMC_OFF_STRAP, q);
        `CHK(q, 32'h70)
        `CHK({bootFromMemory, waitForLoad, linkWide}, 3'b100)
        irqIn <= 4'hf;
        repeat (3) @(posedge sys_clk);
        irqIn <= 4'h0;
        rd(`RSMC_OFF_STATUS, q);
        `CHK(q[3:0], 4'h0)
        $display("Default straps done");
        for (int i = 0; i < 8; i++) begin
            v = 4'($random(seed));
            vr = 1'($random(seed));
            if (i < 2)
                v = {4{i[0]}};
            vectorsReady <= vr;
            do_reset(v);
            `CHK({bootFromMemory, waitForLoad}, {~v[0], v[0]})
            `CHK(linkWide, v[2])
            `CHK(flagOe, 4'h0)
            rd(`RSMC_OFF_STRAP, q);
            `CHK(q, {25'h0, 3'b111, v})
            rd(`RSMC_OFF_IRQCTL, q);
            `CHK(q[7:0], {{4{v[1]}}, {4{v[1] & vr}}})
            r = $random(seed);
            for (int j = 0; j < 2; j++) begin
                wr(j ? `RSMC_OFF_SDRCFG : `RSMC_OFF_SYSCFG, r);
                wr(j ? `RSMC_OFF_SDRCFG : `RSMC_OFF_SYSCFG, ~r);
                rd(j ? `RSMC_OFF_SDRCFG : `RSMC_OFF_SYSCFG, q);
                `CHK(q, v[3] ? ~r : r)
            end
            {linkCompareOut, lockedTransferPin} <= r[5:2];
            {busMasterIndicator, bootMemorySelect} <= r[1:0];
            flagDrive <= r[11:8];
            flagDriveEn <= ~r[3:0];
            wr(`RSMC_OFF_FLAGDIR, {28'h0, r[3:0]});
            wr(`RSMC_OFF_FLAGOUT, {28'h0, r[7:4]});
            `CHK(strapPinOut & 7'h7b, {r[5:2], 1'b0, r[1:0]})
            `CHK(flagOe, r[3:0])
            `CHK(flagOut, r[7:4])
            rd(`RSMC_OFF_FLAGIN, q);
            `CHK(q[3:0], flag_level(r[3:0], r[7:4], r[11:8]))
            wr(`RSMC_OFF_STRAP, 32'h0);
            rd(`RSMC_OFF_STRAP, q);
            `CHK(q, {25'h0, 3'b111, v})
        end
        $display("Strap capture loop done");
        rd(8'h3c, q);
        `CHK(q, 32'h0)
        wr(`RSMC_OFF_IRQCTL, 32'h0f);
        wr(`RSMC_OFF_MASK, 32'h0);
        wr(`RSMC_OFF_STATUS, 32'h1f);
        irqIn <= 4'h2;
        repeat (3) @(posedge sys_clk);
        irqIn <= 4'h0;
        rd(`RSMC_OFF_STATUS, q);
        `CHK(q[3:0], 4'h2)
        `CHK(irq, 1'b0)
        wr(`RSMC_OFF_MASK, 32'h2);
        @(negedge sys_clk);
        `CHK(irq, 1'b1)
        wr(`RSMC_OFF_STATUS, 32'h2);
        @(negedge sys_clk);
        `CHK(irq, 1'b0)
        wr(`RSMC_OFF_IRQCTL, 32'hff);
        irqIn <= 4'h4;
        wr(`RSMC_OFF_STATUS, 32'h4);
        `CHK(irqEvent, 4'h4)
        rd(`RSMC_OFF_STATUS, q);
        `CHK(q[2], 1'b1)
        irqIn <= 4'h0;
        $display("Interrupt test done");
        wr(`RSMC_OFF_STATUS, 32'h1f);
        wr(`RSMC_OFF_TIMER, 32'h8000_0005);
        n = 0;
        while (strapPinOut[2] !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (strapPinOut[2] === 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(n, `RSMC_EXPIRE_PULSE_CYC)
        wr(`RSMC_OFF_TIMER, 32'h0);
        rd(`RSMC_OFF_STATUS, q);
        `CHK(q[`RSMC_STAT_TIMER], 1'b1)
        $display("Timer test done");
        stop_test();
    end
endmodule : reset_strap_mode_capture_test
